// *** rtl/tssd_defs.svh ***
/*
  Named constants of the thermal sensor / presence-detect serial slave:
  address codes, field positions, reset values and timing figures.
  Assumes it is included once per compilation unit before use.
*/
`ifndef TSSD_DEFS_SVH
`define TSSD_DEFS_SVH

`define TSSD_CLK_KHZ 100000
`define TSSD_TOUT_MS 50
`define TSSD_CONV_MS 125
`define TSSD_PWRUP_MS 250

`define TSSD_DTI_TS 4'h3
`define TSSD_DTI_EE 4'hA
`define TSSD_DTI_WP 4'h6
`define TSSD_SEL_SWP 3'h1
`define TSSD_SEL_CWP 3'h3

`define TSSD_DTI_RANGE 7:4
`define TSSD_SEL_RANGE 3:1
`define TSSD_RW_BIT 0
`define TSSD_PTR_RANGE 2:0
`define TSSD_MSB 7
`define TSSD_EE_HALF_BIT 7

`define TSSD_BYTE_BITS 4'h8
`define TSSD_IDX_PTR 2'h0
`define TSSD_IDX_HI 2'h1
`define TSSD_IDX_LO 2'h2
`define TSSD_IDX_OVER 2'h3

`define TSSD_PTR_RST 3'h0
`define TSSD_PTR_CAP 3'h0
`define TSSD_PTR_CFG 3'h1
`define TSSD_PTR_UPPER 3'h2
`define TSSD_PTR_LOWER 3'h3
`define TSSD_PTR_CRIT 3'h4
`define TSSD_PTR_TEMP 3'h5
`define TSSD_PTR_MID 3'h6
`define TSSD_PTR_DID 3'h7

`define TSSD_CAP_VAL 16'h000F
`define TSSD_LIM_RST 16'h0000
`define TSSD_QUERY_BYTE 8'hFF

`endif

// *** rtl/tssd_pkg.sv ***
/*
  Types shared by the serial slave: states, address targets and the
  packed carriers for limits, memory writes and protection commands.
  Assumes nothing of its surroundings.
*/
package tssd_pkg;

  typedef enum logic [2:0] {
    st_idle, st_rx, st_ack, st_tx, st_mack
  } tssd_state_t;

  typedef enum logic [2:0] {
    tgt_none, tgt_ts, tgt_ee, tgt_wp_set, tgt_wp_clr, tgt_wp_perm
  } tssd_target_t;

  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] crit;
  } tssd_limits_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } tssd_ee_wr_t;

  typedef struct packed {
    logic set_rev;
    logic clear;
    logic perm;
  } tssd_wp_cmd_t;

endpackage : tssd_pkg

// *** rtl/tssd_slave.sv ***
/*
  Two-wire serial slave front end of a temperature sensor with a
  presence-detect memory: start/stop/ack, address decode, pointer
  framing, sensor register set, bus timeout and power-up defaults.
  Assumes the bus clock and data arrive unsynchronised from pins, the
  memory array and protection state live outside, and alarm logic
  drives alert_req on this clock.
*/
// Summary of operation
// - Bytes shift MSB first, one bit per clock
// - Pointer resets to zero, capability register
// - Pointer holds last value; registers read-only or writable
// - Read with pointer set returns two bytes
// - Master ack or nack ends read; nack final
// - Measurement may take 125 ms after read
// - Sensor bus timeout no longer than 50 ms
// - Start is data falling while clock high
// - Receiver pulls data low in ack clock
// - Address: four type bits plus sampled pins
// - Type codes select sensor, memory or protection
// - Eighth address bit: one read, zero write
// - Select 001 sets or queries reversible protection
// - Select 011 clears or queries protection
// - Select matching pins sets or queries permanent
// - Floating select pin reads as zero
// - Power-up: monitor, alert released, limits zero
// - Power-up: capability 000Fh, comparator mode
// - First measurement valid 250 ms after power
// - Alert output open-drain and active low
// - Pointer uses only its three low bits
// - Protection covers only lower memory half
`timescale 1ns/100ps
`include "tssd_defs.svh"
module tssd_slave
  import tssd_pkg::*;
#(
  parameter int TOUT_CYC = `TSSD_TOUT_MS * `TSSD_CLK_KHZ,
  parameter int CONV_CYC = `TSSD_CONV_MS * `TSSD_CLK_KHZ,
  parameter int PWRUP_CYC = `TSSD_PWRUP_MS * `TSSD_CLK_KHZ,
  // Identification words: arbitrary values
  parameter logic [15:0] MFR_ID = 16'h1234,
  parameter logic [15:0] DEV_ID = 16'h5678
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic alert_req,
  output logic alert_out,
  output logic alert_oe,
  input wire logic [15:0] temp_value,
  output tssd_limits_t lim,
  output logic [2:0] reg_ptr,
  output logic meas_start,
  output logic meas_busy,
  output logic temp_valid,
  output logic [7:0] ee_addr,
  input wire logic [7:0] ee_rd_data,
  output tssd_ee_wr_t ee_wr,
  input wire logic wp_rev_state,
  input wire logic wp_perm_state,
  output tssd_wp_cmd_t wp_cmd
);

  tssd_state_t state;
  tssd_target_t target;
  tssd_target_t next_target;
  logic scl_s, sda_s, scl_d, sda_d;
  logic [2:0] pins_s, pins_lat;
  logic scl_rise, scl_fall, start_ev, stop_ev, ev_ok;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] hi_byte;
  logic [7:0] tx_byte;
  logic [15:0] tx_word;
  logic [1:0] byte_idx;
  logic first, is_read, ts_read;
  logic addr_ack, data_ack, rx_ack;
  logic rx_done, wr_byte, mack_rise, read_ack, read_nack;
  logic tout_run, tout_done, conv_done;

  tssd_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
    .clk(clk),
    .srst(srst),
    .d({scl_in, sda_in}),
    .q({scl_s, sda_s})
  );

  tssd_sync #(.W(3), .INIT(3'h0)) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .d({addr_select_bit2, addr_select_bit1, addr_select_bit0}),
    .q(pins_s)
  );

  // Bus timeout only runs while a sensor access holds the clock low
  assign tout_run = (state != st_idle) && (target == tgt_ts) && !scl_s;

  tssd_timer #(.CYCLES(TOUT_CYC)) u_tout (
    .clk(clk),
    .srst(srst),
    .run(tout_run),
    .restart(!tout_run),
    .done(tout_done)
  );

  tssd_timer #(.CYCLES(CONV_CYC)) u_conv (
    .clk(clk),
    .srst(srst),
    .run(1'h1),
    .restart(meas_start),
    .done(conv_done)
  );

  tssd_timer #(.CYCLES(PWRUP_CYC)) u_pwrup (
    .clk(clk),
    .srst(srst),
    .run(1'h1),
    .restart(1'h0),
    .done(temp_valid)
  );

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_ev = scl_s && scl_d && sda_d && !sda_s;
  assign stop_ev = scl_s && scl_d && !sda_d && sda_s;
  assign ev_ok = !start_ev && !stop_ev && !tout_done;

  // Pins are caught once per access so a mid-frame change cannot
  // re-address the device; an open pin is pulled low at the pad.
  always_ff @(posedge clk)
  begin
    if (srst)
      pins_lat <= 3'h0;
    else if (start_ev)
      pins_lat <= pins_s;
  end

  always_comb
  begin
    next_target = tgt_none;
    if (shreg[`TSSD_DTI_RANGE] == `TSSD_DTI_TS &&
        shreg[`TSSD_SEL_RANGE] == pins_lat)
      next_target = tgt_ts;
    else if (shreg[`TSSD_DTI_RANGE] == `TSSD_DTI_EE &&
             shreg[`TSSD_SEL_RANGE] == pins_lat)
      next_target = tgt_ee;
    else if (shreg[`TSSD_DTI_RANGE] == `TSSD_DTI_WP)
    begin
      if (shreg[`TSSD_SEL_RANGE] == `TSSD_SEL_SWP)
        next_target = tgt_wp_set;
      else if (shreg[`TSSD_SEL_RANGE] == `TSSD_SEL_CWP)
        next_target = tgt_wp_clr;
      else if (shreg[`TSSD_SEL_RANGE] == pins_lat)
        next_target = tgt_wp_perm;
    end
    addr_ack = (next_target != tgt_none);
    // A set or clear query is refused while reversible protection is on, a permanent query while permanent protection is on
    if (shreg[`TSSD_RW_BIT])
    begin
      if ((next_target == tgt_wp_set || next_target == tgt_wp_clr) &&
          wp_rev_state)
        addr_ack = 1'h0;
      if (next_target == tgt_wp_perm && wp_perm_state)
        addr_ack = 1'h0;
    end
  end

  // A fourth sensor data byte, after the pointer and two register bytes, is refused
  assign data_ack = !(target == tgt_ts && byte_idx == `TSSD_IDX_OVER);
  assign rx_ack = first ? addr_ack : data_ack;

  assign rx_done = ev_ok && (state == st_rx) && scl_fall &&
                   (bit_cnt == `TSSD_BYTE_BITS);
  assign wr_byte = rx_done && !first && !is_read;
  assign mack_rise = ev_ok && (state == st_mack) && scl_rise;
  assign read_ack = mack_rise && !sda_s;
  assign read_nack = mack_rise && sda_s;

  always_comb
  begin
    unique case (reg_ptr)
      `TSSD_PTR_CAP: tx_word = `TSSD_CAP_VAL;
      `TSSD_PTR_CFG: tx_word = lim.cfg;
      `TSSD_PTR_UPPER: tx_word = lim.upper;
      `TSSD_PTR_LOWER: tx_word = lim.lower;
      `TSSD_PTR_CRIT: tx_word = lim.crit;
      `TSSD_PTR_TEMP: tx_word = temp_value;
      `TSSD_PTR_MID: tx_word = MFR_ID;
      `TSSD_PTR_DID: tx_word = DEV_ID;
    endcase
    if (target == tgt_ee)
      tx_byte = ee_rd_data;
    else if (target == tgt_ts)
      tx_byte = byte_idx[0] ? tx_word[7:0] : tx_word[15:8];
    else
      tx_byte = `TSSD_QUERY_BYTE;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= st_idle;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      sda_oe <= 1'h0;
      first <= 1'h0;
      is_read <= 1'h0;
      target <= tgt_none;
      byte_idx <= `TSSD_IDX_PTR;
    end
    else if (start_ev)
    begin
      // Also a repeated start, or the start that ends bus recovery
      state <= st_rx;
      first <= 1'h1;
      bit_cnt <= 4'h0;
      sda_oe <= 1'h0;
    end
    else if (stop_ev || tout_done)
    begin
      state <= st_idle;
      sda_oe <= 1'h0;
    end
    else
    begin
      unique case (state)
        st_idle:
          bit_cnt <= 4'h0;
        st_rx:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (rx_done)
          begin
            if (first)
            begin
              first <= 1'h0;
              target <= next_target;
              is_read <= shreg[`TSSD_RW_BIT];
              byte_idx <= `TSSD_IDX_PTR;
            end
            else if (byte_idx != `TSSD_IDX_OVER)
              byte_idx <= byte_idx + 2'h1;
            sda_oe <= rx_ack;
            state <= rx_ack ? st_ack : st_idle;
          end
        end
        st_ack:
        begin
          if (scl_fall)
          begin
            if (is_read)
            begin
              state <= st_tx;
              shreg <= tx_byte;
              sda_oe <= !tx_byte[`TSSD_MSB];
              bit_cnt <= 4'h1;
            end
            else
            begin
              state <= st_rx;
              sda_oe <= 1'h0;
              bit_cnt <= 4'h0;
            end
          end
        end
        st_tx:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == `TSSD_BYTE_BITS)
            begin
              sda_oe <= 1'h0;
              state <= st_mack;
            end
            else
            begin
              sda_oe <= !shreg[6];
              shreg <= {shreg[6:0], 1'h0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        st_mack:
        begin
          if (read_nack)
            state <= st_idle;
          else if (read_ack)
          begin
            state <= st_ack;
            byte_idx <= byte_idx + 2'h1;
          end
        end
      endcase
    end
  end

  // Sensor register set; pointer persists across accesses
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_ptr <= `TSSD_PTR_RST;
      hi_byte <= 8'h00;
      lim.cfg <= `TSSD_LIM_RST;
      lim.upper <= `TSSD_LIM_RST;
      lim.lower <= `TSSD_LIM_RST;
      lim.crit <= `TSSD_LIM_RST;
    end
    else if (wr_byte && target == tgt_ts)
    begin
      case (byte_idx)
        `TSSD_IDX_PTR:
          reg_ptr <= shreg[`TSSD_PTR_RANGE];
        `TSSD_IDX_HI:
          hi_byte <= shreg;
        `TSSD_IDX_LO:
        begin
          // Read-only locations silently keep their value
          case (reg_ptr)
            `TSSD_PTR_CFG: lim.cfg <= {hi_byte, shreg};
            `TSSD_PTR_UPPER: lim.upper <= {hi_byte, shreg};
            `TSSD_PTR_LOWER: lim.lower <= {hi_byte, shreg};
            `TSSD_PTR_CRIT: lim.crit <= {hi_byte, shreg};
            default: hi_byte <= hi_byte;
          endcase
        end
        default: hi_byte <= hi_byte;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ee_addr <= 8'h00;
      ee_wr <= '0;
    end
    else
    begin
      ee_wr.valid <= 1'h0;
      if (wr_byte && target == tgt_ee)
      begin
        if (byte_idx == `TSSD_IDX_PTR)
          ee_addr <= shreg;
        else
        begin
          // Upper half stays writable whatever the protection state
          ee_wr.valid <= ee_addr[`TSSD_EE_HALF_BIT] ||
                         !(wp_rev_state || wp_perm_state);
          ee_wr.addr <= ee_addr;
          ee_wr.data <= shreg;
          ee_addr <= ee_addr + 8'h01;
        end
      end
      else if (mack_rise && target == tgt_ee)
        ee_addr <= ee_addr + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      wp_cmd <= '0;
    else
    begin
      wp_cmd <= '0;
      if (wr_byte && byte_idx == `TSSD_IDX_PTR)
      begin
        wp_cmd.set_rev <= (target == tgt_wp_set);
        wp_cmd.clear <= (target == tgt_wp_clr);
        wp_cmd.perm <= (target == tgt_wp_perm);
      end
    end
  end

  // End of a sensor read, by nack, stop, start or timeout, starts
  // the next conversion.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ts_read <= 1'h0;
      meas_start <= 1'h0;
      meas_busy <= 1'h1;
    end
    else
    begin
      meas_busy <= !conv_done;
      meas_start <= 1'h0;
      if (rx_done && first && addr_ack && next_target == tgt_ts &&
          shreg[`TSSD_RW_BIT])
        ts_read <= 1'h1;
      else if (ts_read &&
               (read_nack || stop_ev || start_ev || tout_done))
      begin
        ts_read <= 1'h0;
        meas_start <= 1'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      alert_oe <= 1'h0;
      alert_out <= 1'h0;
      sda_out <= 1'h0;
    end
    else
    begin
      alert_oe <= alert_req;
      alert_out <= 1'h0;
      sda_out <= 1'h0;
    end
  end

endmodule : tssd_slave

// *** rtl/tssd_sync.sv ***
/*
  Two-flop synchroniser for a group of asynchronous pins.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/100ps
module tssd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : tssd_sync

// *** rtl/tssd_timer.sv ***
/*
  Interval timer: counts clock cycles while run is high and raises a
  sticky done after CYCLES of them; restart or reset clears it.
  Assumes CYCLES is at least one.
*/
`timescale 1ns/100ps
module tssd_timer #(
  parameter int CYCLES = 16
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic restart,
  output logic done
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] count;

  always_ff @(posedge clk)
  begin
    if (srst || restart)
    begin
      count <= '0;
      done <= 1'h0;
    end
    else if (run && !done)
    begin
      if (count == LAST)
        done <= 1'h1;
      else
        count <= count + 1'h1;
    end
  end

endmodule : tssd_timer

// *** tb/tssd_bus_master.sv ***
/*
  Behavioural two-wire bus master for the serial slave bench.
  Assumes a 100 MHz clk, an SCL period of 16 clk and a pull-up on SDA.
*/
`timescale 1ns/100ps
module tssd_bus_master (
  input wire logic clk,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  logic m_low = 1'b0;
  initial scl = 1'b1;
  // Pull-up: the wire is high unless a party pulls it low
  assign sda = !(m_low || (sda_oe && !sda_out));

  // Quarter bit period: keeps setup and hold well clear of SCL edges
  task automatic q;
    repeat (4) @(negedge clk);
  endtask : q

  task automatic start_c;
    m_low = 1'b0;
    q;
    scl = 1'b1;
    q;
    m_low = 1'b1;
    q;
    scl = 1'b0;
    q;
  endtask : start_c

  task automatic stop_c;
    m_low = 1'b1;
    q;
    scl = 1'b1;
    q;
    m_low = 1'b0;
    q;
  endtask : stop_c

  // SCL only toggles inside frames; it rests high between them
  task automatic bit_x(input logic b, output logic r);
    m_low = !b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
    q;
  endtask : bit_x

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : put_byte

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask : get_byte
endmodule : tssd_bus_master

// *** tb/tssd_slave_bench.sv ***
/*
  Self-checking bench of the serial slave with a bus master model.
  Assumes package, design, master model and checker compiled first.
*/
`timescale 1ns/100ps
module tssd_slave_bench;
  import tssd_pkg::*;
  localparam int PWRUP = 100;
  localparam logic [2:0] PINS = 3'h5;
  localparam logic [7:0] TSW = {4'h3, PINS, 1'b0};
  logic clk, srst, scl, sda, sda_out, sda_oe, alert_req, alert_oe;
  logic meas_start, temp_valid, wp_rev, wp_perm, a;
  logic [2:0] pins, reg_ptr;
  logic [4:0] seen;
  logic [7:0] d, ee_a;
  logic [15:0] v, wr_last;
  tssd_limits_t lim;
  tssd_ee_wr_t ee_wr;
  tssd_wp_cmd_t wp_cmd;
  int bad_count, num_checks;

  tssd_slave #(.TOUT_CYC(200), .CONV_CYC(50), .PWRUP_CYC(PWRUP)) u_dut (
    .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_bit0(pins[0]),
    .addr_select_bit1(pins[1]), .addr_select_bit2(pins[2]),
    .alert_req(alert_req), .alert_out(), .alert_oe(alert_oe),
    .temp_value(16'h0190), .lim(lim), .reg_ptr(reg_ptr),
    .meas_start(meas_start), .meas_busy(), .temp_valid(temp_valid),
    .ee_addr(ee_a), .ee_rd_data(8'hC3), .ee_wr(ee_wr),
    .wp_rev_state(wp_rev), .wp_perm_state(wp_perm), .wp_cmd(wp_cmd));
  tssd_bus_master u_mst (.clk(clk), .sda_oe(sda_oe),
    .sda_out(sda_out), .scl(scl), .sda(sda));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // One-cycle pulses are caught here so tasks can judge them later
  always @(posedge clk)
  begin
    seen = seen | {wp_cmd, ee_wr.valid, meas_start};
    if (ee_wr.valid)
      wr_last = {ee_wr.addr, ee_wr.data};
  end

  task automatic chk(input string n, input logic [15:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  function automatic logic [7:0] ab(logic [3:0] t, logic [2:0] s, logic r);
    return {t, s, r};
  endfunction : ab

  task automatic send(input logic [7:0] b[$], input logic [7:0] acks);
    u_mst.start_c;
    foreach (b[i])
    begin
      u_mst.put_byte(b[i], a);
      chk("ack", acks[i], a);
    end
    u_mst.stop_c;
  endtask : send

  task automatic rd(input logic [7:0] p, input logic [15:0] e);
    u_mst.start_c;
    u_mst.put_byte(TSW, a);
    u_mst.put_byte(p, a);
    u_mst.start_c;
    u_mst.put_byte(ab(4'h3, PINS, 1'b1), a);
    chk("rd ack", 1, a);
    u_mst.get_byte(1'b0, v[15:8]);
    u_mst.get_byte(1'b1, v[7:0]);
    u_mst.stop_c;
    chk("rd data", e, v);
  endtask : rd

  task automatic t_reset;
    chk("ptr", 0, reg_ptr);
    chk("limits", 0, lim.upper | lim.lower | lim.crit | lim.cfg);
    chk("early valid", 0, temp_valid);
    repeat (PWRUP + 5) @(negedge clk);
    chk("valid", 1, temp_valid);
    $display("test reset done");
  endtask : t_reset

  task automatic t_write;
    send({TSW, 8'h02, 8'h12, 8'h34}, 8'h0F);
    send({TSW, 8'h04, 8'h01, 8'h23}, 8'h0F);
    send({TSW, 8'h0B, 8'h55}, 8'h07);
    chk("upper", 16'h1234, lim.upper);
    chk("crit", 16'h0123, lim.crit);
    chk("ptr", 3, reg_ptr);
    chk("lower", 0, lim.lower);
    send({TSW, 8'h00, 8'hBE, 8'hEF, 8'hBE}, 8'h0F);
    $display("test write done");
  endtask : t_write

  task automatic t_read;
    seen = 0;
    u_mst.start_c;
    u_mst.put_byte(ab(4'h3, PINS, 1'b1), a);
    u_mst.get_byte(1'b0, v[15:8]);
    u_mst.get_byte(1'b1, v[7:0]);
    u_mst.stop_c;
    chk("cap", 16'h000F, v);
    chk("meas", 1, seen[0]);
    rd(8'h04, 16'h0123);
    chk("ptr", 4, reg_ptr);
    rd(8'h05, 16'h0190);
    $display("test read done");
  endtask : t_read

  task automatic t_addr;
    send({ab(4'h5, PINS, 1'b0)}, 8'h00);
    send({ab(4'h3, 3'h2, 1'b0)}, 8'h00);
    pins = 3'h2;
    send({ab(4'h3, 3'h2, 1'b0), 8'h04}, 8'h03);
    pins = PINS;
    $display("test address done");
  endtask : t_addr

  task automatic t_mem;
    logic [2:0] sl [3] = '{3'h1, 3'h3, PINS};
    send({ab(4'hA, PINS, 1'b0), 8'h85, 8'h5A}, 8'h07);
    chk("mem wr", 16'h855A, wr_last);
    u_mst.start_c;
    u_mst.put_byte(ab(4'hA, PINS, 1'b1), a);
    u_mst.get_byte(1'b1, d);
    u_mst.stop_c;
    chk("mem rd", 8'hC3, d);
    chk("mem addr", 8'h87, ee_a);
    for (int i = 0; i < 3; i++)
    begin
      seen = 0;
      send({ab(4'h6, sl[i], 1'b0), 8'h00}, 8'h03);
      chk("prot cmd", 3'h4 >> i, seen[4:2]);
    end
    wp_rev = 1'b1;
    seen = 0;
    send({ab(4'hA, PINS, 1'b0), 8'h10, 8'h77}, 8'h07);
    chk("low blocked", 0, seen[1]);
    send({ab(4'hA, PINS, 1'b0), 8'h90, 8'h77}, 8'h07);
    chk("high written", 16'h9077, wr_last);
    send({ab(4'h6, 3'h1, 1'b1)}, 8'h00);
    wp_rev = 1'b0;
    u_mst.start_c;
    u_mst.put_byte(ab(4'h6, 3'h3, 1'b1), a);
    chk("query ack", 1, a);
    u_mst.get_byte(1'b1, d);
    u_mst.stop_c;
    chk("query data", 8'hFF, d);
    wp_perm = 1'b1;
    send({ab(4'h6, PINS, 1'b1)}, 8'h00);
    seen = 0;
    send({ab(4'hA, PINS, 1'b0), 8'h20, 8'h77}, 8'h07);
    chk("perm blocked", 0, seen[1]);
    wp_perm = 1'b0;
    $display("test memory done");
  endtask : t_mem

  task automatic t_abort;
    u_mst.start_c;
    for (int i = 0; i < 4; i++)
      u_mst.bit_x(1'b0, a);
    u_mst.stop_c;
    send({TSW, 8'h02}, 8'h03);
    chk("ptr", 2, reg_ptr);
    u_mst.start_c;
    for (int i = 0; i < 13; i++)
      u_mst.bit_x(i > 3, a);
    rd(8'h04, 16'h0123);
    $display("test abort done");
  endtask : t_abort

  task automatic t_tout;
    u_mst.start_c;
    u_mst.put_byte(ab(4'h3, PINS, 1'b1), a);
    chk("first bit", 1, sda_oe);
    repeat (220) @(negedge clk);
    chk("released", 0, sda_oe);
    u_mst.stop_c;
    alert_req = 1'b1;
    repeat (3) @(negedge clk);
    chk("alert", 1, alert_oe);
    alert_req = 1'b0;
    repeat (3) @(negedge clk);
    chk("alert off", 0, alert_oe);
    $display("test timeout and alert done");
  endtask : t_tout

  initial
  begin
    #500_000;
    bad_count++;
    complete_run;
  end

  initial
  begin
    srst = 1'b1;
    alert_req = 1'b0;
    wp_rev = 1'b0;
    wp_perm = 1'b0;
    pins = PINS;
    seen = 0;
    bad_count = 0;
    num_checks = 0;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset;
    t_write;
    t_read;
    t_addr;
    t_mem;
    t_abort;
    t_tout;
    complete_run;
  end
endmodule : tssd_slave_bench

// *** tb/tssd_slave_sva.sv ***
/*
  Port assertions of the serial slave.
  Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/100ps
module tssd_slave_chk
  import tssd_pkg::*;
#(
  parameter int PWRUP_CYC = 100
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic alert_req,
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire tssd_limits_t lim,
  input wire logic [2:0] reg_ptr,
  input wire logic meas_start,
  input wire logic meas_busy,
  input wire logic temp_valid,
  input wire tssd_wp_cmd_t wp_cmd
);
  int up_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  always_ff @(posedge clk)
    if (srst)
      up_cnt <= 0;
    else if (up_cnt < PWRUP_CYC)
      up_cnt <= up_cnt + 1;

  // The busy level is a register behind the timer's done flag, so it
  // shows the restart two cycles after the start pulse is sampled
  sequence s_conv;
    ##2 meas_busy [*3];
  endsequence

  a_ptr_reset: assert property ($fell(srst) |-> reg_ptr == 3'h0)
    else $error("pointer not zero after reset");
  a_lim_reset: assert property ($fell(srst) |-> lim == '0)
    else $error("limits not zero after reset");
  a_alert_copy: assert property (!$past(srst) |->
    alert_oe == $past(alert_req))
    else $error("alert pin does not follow request");
  a_open_drain: assert property (!sda_out && !alert_out)
    else $error("open-drain output driven high");
  a_ptr_hold: assert property ($changed(reg_ptr) |-> !scl_in)
    else $error("pointer changed while clock high");
  a_oe_steady: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line changed while clock high");
  a_conv_busy: assert property (meas_start |-> s_conv)
    else $error("measurement not busy after read");
  a_valid_wait: assert property (temp_valid |->
    up_cnt >= PWRUP_CYC - 2)
    else $error("temperature valid too early");
  a_wp_pulse: assert property (wp_cmd != '0 |=> wp_cmd == '0)
    else $error("protection command longer than a pulse");
endmodule : tssd_slave_chk

bind tssd_slave tssd_slave_chk #(.PWRUP_CYC(PWRUP_CYC)) u_chk (
  .clk(clk), .srst(srst), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .alert_req(alert_req), .alert_out(alert_out),
  .alert_oe(alert_oe), .lim(lim), .reg_ptr(reg_ptr),
  .meas_start(meas_start), .meas_busy(meas_busy),
  .temp_valid(temp_valid), .wp_cmd(wp_cmd));
